// ===== pcf_defs.svh
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH
// Function
// - phase fifos carry data both ways
// - shallow transmit fifo adds three-four cycles
// - shallow receive fifo adds two-three cycles
// - pass-through mode uses registers, fixed latency
// - optional transmit full flag output
// - optional transmit empty flag output
// - optional receive full flag output
// - optional receive empty flag output
// - optional rate match empty flag output
// - optional rate match full flag output
// - rate match adds or drops skip words
// - byte ordering realigns deserialized symbols
// - byte ordering present only when enabled
// - pattern in msb gets pad inserted

// ----------------------------------------------------------------
// datapath geometry
// ----------------------------------------------------------------
`define PCF_SYM_W 10
`define PCF_DATA_W 20
`define PCF_PC_DEPTH 8
`define PCF_RM_DEPTH 16
`define PCF_TX_VIS 1
`define PCF_RX_VIS 0
`define PCF_RM_HI 5'h0c
`define PCF_RM_LO 5'h04

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCF_OFF_CTRL 5'h00
`define PCF_OFF_BOCFG 5'h04
`define PCF_OFF_SKIP 5'h08
`define PCF_OFF_FLAGS 5'h0c
`define PCF_OFF_ISTAT 5'h10
`define PCF_OFF_IMASK 5'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PCF_C_TX_PASS 0
`define PCF_C_RX_PASS 1
`define PCF_C_FLAG_LSB 2
`define PCF_C_BO_EN 8
`define PCF_C_BO_MAN 9
`define PCF_C_RM_EN 10
`define PCF_CTRL_W 11
`define PCF_CTRL_RST 11'h5fc
`define PCF_BOCFG_RST 20'h0_0000
`define PCF_SKIP_RST 20'h0_0000
`define PCF_NFLAG 6
`define PCF_NINT 8
`define PCF_I_OVF 6
`define PCF_I_BO 7
`endif

// ===== pcf_pkg.sv
`include "pcf_defs.svh"
package pcf_pkg;
   typedef logic [`PCF_DATA_W-1:0] pcf_word_t;
   typedef logic [`PCF_SYM_W-1:0] pcf_sym_t;
   // byte ordering controller states
   typedef enum logic [2:0]
   {
      PCF_BO_WAIT = 3'b001,
      PCF_BO_ARMED = 3'b010,
      PCF_BO_LOCKED = 3'b100
   } pcf_bo_state_t;
endpackage : pcf_pkg

// ===== pcf_stream_if.sv
`timescale 1ns/1ps
`include "pcf_defs.svh"
interface pcf_stream_if
#(
   parameter int W = `PCF_DATA_W
);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src
   (
      output valid,
      output data,
      input ready
   );
   modport snk
   (
      input valid,
      input data,
      output ready
   );
endinterface : pcf_stream_if

// ===== pcf_fifo.sv
`timescale 1ns/1ps
`include "pcf_defs.svh"
module pcf_fifo
   import pcf_pkg::*;
#(
   parameter int DEPTH = `PCF_PC_DEPTH,
   parameter int VIS = 0
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pass,
   pcf_stream_if.snk wr,
   pcf_stream_if.src rd,
   output logic full,
   output logic empty,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int PRE = VIS + 1;
   pcf_word_t mem_reg [DEPTH];
   pcf_word_t dout_reg;
   logic [AW:0] wptr_reg;
   logic [AW:0] rptr_reg;
   logic [AW:0] wvis;
   logic vld_reg;
   logic can_ld;
   logic do_wr;
   logic do_rd;

   // ----------------------------------------------------------------
   // occupancy and handshakes
   // ----------------------------------------------------------------
   assign level = wptr_reg - rptr_reg;
   assign can_ld = !vld_reg || rd.ready;
   assign full = pass ? !can_ld : (level == (AW+1)'(DEPTH));
   assign empty = pass ? !vld_reg : (level == '0 && !vld_reg);
   assign wr.ready = !full;
   assign do_wr = wr.valid && !full;
   assign do_rd = !pass && can_ld && (wvis != rptr_reg);
   assign rd.valid = vld_reg;
   assign rd.data = dout_reg;

   // write pointer seen by the reader late, models the phase margin
   if (VIS == 0)
   begin : g_nodly
      assign wvis = wptr_reg;
   end
   else
   begin : g_dly
      logic [AW:0] dly_reg [VIS];
      always_ff @(posedge clk)
      begin
         if (sys_rst)
         begin
            for (int i = 0; i < VIS; i++)
               dly_reg[i] <= '0;
         end
         else
         begin
            dly_reg[0] <= wptr_reg;
            for (int i = 1; i < VIS; i++)
               dly_reg[i] <= dly_reg[i-1];
         end
      end
      assign wvis = dly_reg[VIS-1];
   end

   // storage write; pointers frozen in pass-through
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wptr_reg <= '0;
      else if (!pass && do_wr)
      begin
         mem_reg[wptr_reg[AW-1:0]] <= wr.data;
         wptr_reg <= wptr_reg + 1'b1;
      end
   end

   // registered read side, or plain register when passing through
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rptr_reg <= '0;
         vld_reg <= 1'b0;
      end
      else if (pass ? do_wr : do_rd)
      begin
         vld_reg <= 1'b1;
         if (!pass)
            rptr_reg <= rptr_reg + 1'b1;
      end
      else if (rd.ready)
         vld_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (pass && do_wr)
         dout_reg <= wr.data;
      else if (do_rd)
         dout_reg <= mem_reg[rptr_reg[AW-1:0]];
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_lat;
      @(posedge clk) disable iff (sys_rst)
      (!pass && do_wr && level == '0 && !vld_reg)
         |-> ##PRE !rd.valid ##1 rd.valid;
   endproperty
   a_lat: assert property (p_lat)
      else $error("shallow fifo latency wrong");

   property p_pass;
      @(posedge clk) disable iff (sys_rst)
      (pass && do_wr) |=> rd.valid && rd.data == $past(wr.data);
   endproperty
   a_pass: assert property (p_pass)
      else $error("pass-through not one register");

   property p_fill;
      @(posedge clk) disable iff (sys_rst)
      (!pass && do_wr && !do_rd && level == (AW+1)'(DEPTH-1))
         |=> full && !wr.ready;
   endproperty
   a_fill: assert property (p_fill)
      else $error("full flag missed last entry");
endmodule : pcf_fifo

// ===== pcf_byte_order.sv
`timescale 1ns/1ps
`include "pcf_defs.svh"
module pcf_byte_order
   import pcf_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic manual,
   input wire logic trigger,
   input wire pcf_sym_t pattern,
   input wire pcf_sym_t pad,
   pcf_stream_if.snk din,
   pcf_stream_if.src dout,
   output logic locked,
   output logic done
);
   pcf_bo_state_t state_reg;
   pcf_bo_state_t state_next;
   pcf_word_t out_reg;
   pcf_sym_t held_reg;
   pcf_sym_t hi;
   pcf_sym_t lo;
   logic vld_reg;
   logic shift_reg;
   logic trig_prev_reg;
   logic take;
   logic edge_t;
   logic aligned;
   logic pad_hit;

   assign din.ready = !vld_reg || dout.ready;
   assign take = din.valid && din.ready;
   assign {hi, lo} = din.data;
   assign edge_t = trigger && !trig_prev_reg;
   assign aligned = shift_reg ? hi == pattern : lo == pattern;
   assign pad_hit = state_reg == PCF_BO_ARMED && take && !shift_reg
      && hi == pattern && lo != pattern;
   assign dout.valid = vld_reg;
   assign dout.data = out_reg;
   assign locked = state_reg == PCF_BO_LOCKED;
   assign done = state_reg == PCF_BO_ARMED && state_next == PCF_BO_LOCKED;

   // arming: auto arms once, manual needs a fresh trigger edge
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         PCF_BO_WAIT:
            if (!manual || edge_t)
               state_next = PCF_BO_ARMED;
         PCF_BO_ARMED:
            if (take && (aligned || pad_hit))
               state_next = PCF_BO_LOCKED;
         PCF_BO_LOCKED:
            if (manual && edge_t)
               state_next = PCF_BO_ARMED;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || !enable)
         state_reg <= PCF_BO_WAIT;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         trig_prev_reg <= 1'b0;
      else
         trig_prev_reg <= trigger;
   end

   // realignment shifter; bypassed whole when disabled
   always_ff @(posedge clk)
   begin
      if (sys_rst || !enable)
         shift_reg <= 1'b0;
      else if (pad_hit)
         shift_reg <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         vld_reg <= 1'b0;
      else if (take)
         vld_reg <= 1'b1;
      else if (dout.ready)
         vld_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (take)
      begin
         held_reg <= hi;
         if (!enable)
            out_reg <= din.data;
         else if (pad_hit)
            out_reg <= {lo, pad};
         else if (shift_reg)
            out_reg <= {lo, held_reg};
         else
            out_reg <= din.data;
      end
   end

   property p_pad;
      @(posedge clk) disable iff (sys_rst)
      pad_hit |=> dout.valid && dout.data == {$past(lo), $past(pad)};
   endproperty
   a_pad: assert property (p_pad)
      else $error("pad not inserted below pattern");

   property p_bypass;
      @(posedge clk) disable iff (sys_rst)
      (!enable && take) |=> dout.data == $past(din.data) && !shift_reg;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("byte ordering acted while disabled");
endmodule : pcf_byte_order

// ===== pcf_phase_comp.sv
`timescale 1ns/1ps
`include "pcf_defs.svh"
module pcf_phase_comp
   import pcf_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   output logic irq,
   input wire pcf_word_t tx_usr_data,
   input wire logic tx_usr_valid,
   output logic tx_usr_ready,
   output pcf_word_t tx_pcs_data,
   output logic tx_pcs_valid,
   input wire logic tx_pcs_ready,
   input wire pcf_word_t rx_pcs_data,
   input wire logic rx_pcs_valid,
   output pcf_word_t rx_usr_data,
   output logic rx_usr_valid,
   input wire logic rx_usr_ready,
   input wire logic bo_trigger,
   output logic tx_full_flag,
   output logic tx_empty_flag,
   output logic rx_full_flag,
   output logic rx_empty_flag,
   output logic rm_full_flag,
   output logic rm_empty_flag
);
   localparam int RMW = $clog2(`PCF_RM_DEPTH) + 1;

   // ----------------------------------------------------------------
   // register file state
   // ----------------------------------------------------------------
   logic [`PCF_CTRL_W-1:0] ctrl_reg;
   logic [`PCF_DATA_W-1:0] bo_cfg_reg;
   pcf_word_t skip_reg;
   logic [`PCF_NINT-1:0] int_stat_reg;
   logic [`PCF_NINT-1:0] int_mask_reg;
   logic [`PCF_NINT-1:0] int_ev;
   logic [`PCF_NINT-1:0] int_clr;
   logic [`PCF_NFLAG-1:0] flag_raw;
   logic [`PCF_NFLAG-1:0] flag_reg;
   logic [`PCF_NFLAG-1:0] flag_out_reg;
   logic [`PCF_NFLAG-1:0] flag_en;
   logic [31:0] rdata_reg;

   // datapath glue
   logic [RMW-1:0] rm_level;
   logic rm_en;
   logic rm_del;
   logic rm_ins;
   logic rm_ovf;
   logic last_skip_reg;
   logic bo_locked;
   logic bo_done;

   pcf_stream_if tx_in_s ();
   pcf_stream_if tx_out_s ();
   pcf_stream_if rm_in_s ();
   pcf_stream_if rm_out_s ();
   pcf_stream_if bo_in_s ();
   pcf_stream_if bo_rx_s ();
   pcf_stream_if rx_out_s ();

   assign rm_en = ctrl_reg[`PCF_C_RM_EN];
   assign flag_en = ctrl_reg[`PCF_C_FLAG_LSB +: `PCF_NFLAG];

   // ----------------------------------------------------------------
   // transmit path: fabric to pcs
   // ----------------------------------------------------------------
   assign tx_in_s.valid = tx_usr_valid;
   assign tx_in_s.data = tx_usr_data;
   assign tx_usr_ready = tx_in_s.ready;
   assign tx_pcs_data = tx_out_s.data;
   assign tx_pcs_valid = tx_out_s.valid;
   assign tx_out_s.ready = tx_pcs_ready;

   // extra pointer stage gives the longer transmit latency
   pcf_fifo #(
      .DEPTH(`PCF_PC_DEPTH),
      .VIS(`PCF_TX_VIS)
   ) u_tx_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .pass(ctrl_reg[`PCF_C_TX_PASS]),
      .wr(tx_in_s),
      .rd(tx_out_s),
      .full(flag_raw[0]),
      .empty(flag_raw[1]),
      .level()
   );

   // ----------------------------------------------------------------
   // receive rate match
   // ----------------------------------------------------------------
   // the pcs cannot stall, so a word that meets a full fifo is lost
   // and only reported; deleting skips early keeps that rare
   assign rm_del = rm_en && rx_pcs_data == skip_reg
      && rm_level >= `PCF_RM_HI;
   assign rm_in_s.valid = rx_pcs_valid && !rm_del;
   assign rm_in_s.data = rx_pcs_data;
   assign rm_ovf = rm_in_s.valid && !rm_in_s.ready;

   pcf_fifo #(
      .DEPTH(`PCF_RM_DEPTH),
      .VIS(0)
   ) u_rm_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .pass(1'b0),
      .wr(rm_in_s),
      .rd(rm_out_s),
      .full(flag_raw[4]),
      .empty(flag_raw[5]),
      .level(rm_level)
   );

   // a skip is repeated only right after a skip, so packets stay whole
   assign rm_ins = rm_en && last_skip_reg && rm_level < `PCF_RM_LO;
   assign bo_in_s.valid = rm_ins || rm_out_s.valid;
   assign bo_in_s.data = rm_ins ? skip_reg : rm_out_s.data;
   assign rm_out_s.ready = bo_in_s.ready && !rm_ins;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         last_skip_reg <= 1'b0;
      else if (bo_in_s.valid && bo_in_s.ready)
         last_skip_reg <= bo_in_s.data == skip_reg;
   end

   // ----------------------------------------------------------------
   // byte ordering and receive phase fifo
   // ----------------------------------------------------------------
   pcf_byte_order u_bo (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(ctrl_reg[`PCF_C_BO_EN]),
      .manual(ctrl_reg[`PCF_C_BO_MAN]),
      .trigger(bo_trigger),
      .pattern(bo_cfg_reg[`PCF_SYM_W-1:0]),
      .pad(bo_cfg_reg[`PCF_DATA_W-1:`PCF_SYM_W]),
      .din(bo_in_s),
      .dout(bo_rx_s),
      .locked(bo_locked),
      .done(bo_done)
   );

   pcf_fifo #(
      .DEPTH(`PCF_PC_DEPTH),
      .VIS(`PCF_RX_VIS)
   ) u_rx_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .pass(ctrl_reg[`PCF_C_RX_PASS]),
      .wr(bo_rx_s),
      .rd(rx_out_s),
      .full(flag_raw[2]),
      .empty(flag_raw[3]),
      .level()
   );

   assign rx_usr_data = rx_out_s.data;
   assign rx_usr_valid = rx_out_s.valid;
   assign rx_out_s.ready = rx_usr_ready;

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   // flags lag the fifo by one cycle; a disabled flag drives its output low but still shows in the flags register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flag_reg <= flag_raw; // idle level, so no false edge after reset
         flag_out_reg <= '0;
      end
      else
      begin
         flag_reg <= flag_raw;
         flag_out_reg <= flag_raw & flag_en;
      end
   end

   assign tx_full_flag = flag_out_reg[0];
   assign tx_empty_flag = flag_out_reg[1];
   assign rx_full_flag = flag_out_reg[2];
   assign rx_empty_flag = flag_out_reg[3];
   assign rm_full_flag = flag_out_reg[4];
   assign rm_empty_flag = flag_out_reg[5];

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   assign int_ev = {bo_done, rm_ovf, flag_raw & ~flag_reg};
   assign int_clr = (reg_we && reg_addr == `PCF_OFF_ISTAT)
      ? reg_wdata[`PCF_NINT-1:0] : '0;

   // a new event outranks a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         int_stat_reg <= '0;
      else
         int_stat_reg <= (int_stat_reg & ~int_clr) | int_ev;
   end

   assign irq = |(int_stat_reg & int_mask_reg);

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl_reg <= `PCF_CTRL_RST;
         bo_cfg_reg <= `PCF_BOCFG_RST;
         skip_reg <= `PCF_SKIP_RST;
         int_mask_reg <= '0;
      end
      else if (reg_we)
      begin
         unique case (reg_addr)
            `PCF_OFF_CTRL:
               ctrl_reg <= reg_wdata[`PCF_CTRL_W-1:0];
            `PCF_OFF_BOCFG:
               bo_cfg_reg <= reg_wdata[`PCF_DATA_W-1:0];
            `PCF_OFF_SKIP:
               skip_reg <= reg_wdata[`PCF_DATA_W-1:0];
            `PCF_OFF_IMASK:
               int_mask_reg <= reg_wdata[`PCF_NINT-1:0];
            default:
               ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register reads, data valid only in the next cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst || !reg_re)
         rdata_reg <= 32'h0000_0000;
      else
      begin
         unique case (reg_addr)
            `PCF_OFF_CTRL:
               rdata_reg <= 32'(ctrl_reg);
            `PCF_OFF_BOCFG:
               rdata_reg <= 32'(bo_cfg_reg);
            `PCF_OFF_SKIP:
               rdata_reg <= 32'(skip_reg);
            `PCF_OFF_FLAGS:
               rdata_reg <= 32'({bo_locked, flag_reg});
            `PCF_OFF_ISTAT:
               rdata_reg <= 32'(int_stat_reg);
            `PCF_OFF_IMASK:
               rdata_reg <= 32'(int_mask_reg);
            default:
               rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_flag_gate;
      @(posedge clk) disable iff (sys_rst)
      !sys_rst |=> flag_out_reg
         == ($past(flag_raw) & $past(flag_en));
   endproperty
   a_flag_gate: assert property (p_flag_gate)
      else $error("status flag not tracking its fifo");

   property p_rm_del;
      @(posedge clk) disable iff (sys_rst)
      (rm_del && !rm_out_s.ready) |=> rm_level == $past(rm_level);
   endproperty
   a_rm_del: assert property (p_rm_del)
      else $error("deleted skip entered rate match fifo");

   property p_rm_ins;
      @(posedge clk) disable iff (sys_rst)
      rm_ins |-> bo_in_s.valid && bo_in_s.data == skip_reg
         && !rm_out_s.ready;
   endproperty
   a_rm_ins: assert property (p_rm_ins)
      else $error("inserted word is not a skip");

   property p_set_wins;
      @(posedge clk) disable iff (sys_rst)
      (int_ev[`PCF_I_OVF] && int_clr[`PCF_I_OVF])
         |=> int_stat_reg[`PCF_I_OVF];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost under clear");
endmodule : pcf_phase_comp

// ===== pcf_fabric_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// fabric side: receive sink and byte-order trigger
// ----------------------------------------------------------------
module pcf_fabric_model
(
   input wire logic clk,
   input wire logic slow,
   input wire logic pulse_req,
   output logic rx_usr_ready,
   output logic bo_trigger
);
   logic [1:0] ph_reg;
   // slow mode takes one word in four, a fabric that lags behind
   always @(posedge clk)
   begin
      ph_reg <= ph_reg + 2'h1;
      rx_usr_ready <= !slow || ph_reg == 2'h3;
   end
   // one high cycle per request, low again before the next one
   always @(posedge clk)
   begin
      bo_trigger <= pulse_req && !bo_trigger;
   end
   initial
   begin
      ph_reg = 2'h0;
      rx_usr_ready = 1'b1;
      bo_trigger = 1'b0;
   end
endmodule : pcf_fabric_model

// ===== test_pcf_phase_comp.sv
`timescale 1ns/1ps
`include "pcf_defs.svh"
module test_pcf_phase_comp
   import pcf_pkg::*;
();
   logic clk, sys_rst, reg_we, reg_re, irq, slow, pulse_req;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, seed;
   logic tx_usr_valid, tx_usr_ready, tx_pcs_valid, tx_pcs_ready;
   logic rx_pcs_valid, rx_usr_valid, rx_usr_ready, bo_trigger;
   logic tx_full_flag, tx_empty_flag, rx_full_flag, rx_empty_flag;
   logic rm_full_flag, rm_empty_flag, bo_on, bo_arm, bo_shift;
   pcf_word_t tx_usr_data, tx_pcs_data, rx_pcs_data, rx_usr_data, skip_w;
   pcf_word_t txq[$], rxq[$];
   pcf_sym_t bo_pat, bo_pad, prev_hi;
   int txt[$], rxt[$];
   int error_cnt, total_checks, cyc, tt, tx_lat, rx_lat, skip_cnt;

   pcf_phase_comp i_dut (.*);
   pcf_fabric_model i_fabric (.clk(clk), .slow(slow),
      .pulse_req(pulse_req), .rx_usr_ready(rx_usr_ready),
      .bo_trigger(bo_trigger));

   always #2 clk = ~clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // expected receive word; shift state lives across calls
   function automatic pcf_word_t bo_xf(input pcf_word_t w);
      pcf_word_t o;
      o = w;
      if (bo_on && bo_shift)
         o = {w[9:0], prev_hi};
      else if (bo_on && bo_arm && w[9:0] == bo_pat)
         bo_arm = 1'b0;
      else if (bo_on && bo_arm && w[19:10] == bo_pat)
      begin
         o = {w[9:0], bo_pad};
         bo_arm = 1'b0;
         bo_shift = 1'b1;
      end
      prev_hi = w[19:10];
      return o;
   endfunction : bo_xf
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
      @(posedge clk);
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      check(reg_rdata, e);
      @(posedge clk);
   endtask : rd
   // ready is judged at the falling edge, where it has settled
   task automatic tx_send(input int n);
      repeat (n)
      begin
         tx_usr_data <= pcf_word_t'(rnd());
         tx_usr_valid <= 1'b1;
         do @(negedge clk); while (!tx_usr_ready);
         @(posedge clk);
      end
      tx_usr_valid <= 1'b0;
   endtask : tx_send
   task automatic rx_send(input pcf_word_t w);
      rx_pcs_data <= w;
      rx_pcs_valid <= 1'b1;
      @(posedge clk);
   endtask : rx_send

   // ----------------------------------------------------------------
   // reference model: order, data and latency of both streams
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (tx_usr_valid && tx_usr_ready)
      begin
         txq.push_back(tx_usr_data);
         txt.push_back(cyc);
      end
      if (tx_pcs_valid && tx_pcs_ready)
      begin
         check(32'(tx_pcs_data), 32'(txq.pop_front()));
         tt = txt.pop_front();
         if (tx_lat != 0)
            check(32'(cyc - tt), 32'(tx_lat));
      end
      if (rx_pcs_valid && (skip_w == '0 || rx_pcs_data != skip_w))
      begin
         rxq.push_back(bo_xf(rx_pcs_data));
         rxt.push_back(cyc);
      end
      // skips are counted, not queued: rate match may add them
      if (rx_usr_valid && rx_usr_ready && skip_w != '0
         && rx_usr_data == skip_w)
         skip_cnt++;
      else if (rx_usr_valid && rx_usr_ready)
      begin
         check(32'(rx_usr_data), 32'(rxq.pop_front()));
         tt = rxt.pop_front();
         if (rx_lat != 0)
            check(32'(cyc - tt), 32'(rx_lat));
      end
      cyc = cyc + 1;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {clk, reg_we, reg_re, tx_usr_valid, rx_pcs_valid} = '0;
      {slow, pulse_req, bo_on, bo_arm, bo_shift} = '0;
      {reg_addr, reg_wdata, tx_usr_data, rx_pcs_data, skip_w} = '0;
      {error_cnt, total_checks, cyc, tx_lat, rx_lat, skip_cnt} = '0;
      tx_pcs_ready = 1'b1;
      seed = 32'h0001_78a2;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // idle state after reset, unmapped place reads zero
      rd(`PCF_OFF_CTRL, 32'h0000_05fc);
      rd(`PCF_OFF_FLAGS, 32'h0000_002a);
      rd(5'h18, 32'h0000_0000);
      rd(`PCF_OFF_ISTAT, 32'h0000_0000);
      check(32'({tx_full_flag, tx_empty_flag, rx_full_flag, rx_empty_flag,
         rm_full_flag, rm_empty_flag}), 32'h0000_0015);
      $display("end of test: reset");
      // shallow then pass-through latency in both directions
      wr(`PCF_OFF_CTRL, 32'h0000_00fc);
      {tx_lat, rx_lat} = {32'd3, 32'd5};
      rx_send(pcf_word_t'(rnd()));
      rx_pcs_valid <= 1'b0;
      tx_send(1);
      repeat (8) @(posedge clk);
      wr(`PCF_OFF_CTRL, 32'h0000_00ff);
      {tx_lat, rx_lat} = {32'd1, 32'd4};
      rx_send(pcf_word_t'(rnd()));
      rx_pcs_valid <= 1'b0;
      tx_send(1);
      repeat (8) @(posedge clk);
      $display("end of test: latency");
      // fill transmit side until refused, then drain it
      wr(`PCF_OFF_CTRL, 32'h0000_00fc);
      {tx_lat, rx_lat} = '0;
      tx_pcs_ready <= 1'b0;
      tx_send(9);
      repeat (2) @(negedge clk);
      check(32'({tx_usr_ready, tx_full_flag}), 32'h0000_0001);
      @(posedge clk);
      tx_pcs_ready <= 1'b1;
      repeat (14) @(posedge clk);
      check(32'(tx_empty_flag), 32'h0000_0001);
      // receive burst against a slow fabric
      slow <= 1'b1;
      repeat (6) rx_send(pcf_word_t'(rnd()));
      rx_pcs_valid <= 1'b0;
      repeat (40) @(posedge clk);
      slow <= 1'b0;
      $display("end of test: fill and drain");
      // rate match: a skip is repeated while the fifo runs low, and the
      // data word behind it waits until matching is switched off
      skip_w = 20'h5_a5a5;
      wr(`PCF_OFF_SKIP, 32'(skip_w));
      wr(`PCF_OFF_CTRL, 32'h0000_04fc);
      rx_send(skip_w);
      rx_send(pcf_word_t'(rnd()));
      rx_pcs_valid <= 1'b0;
      repeat (20) @(posedge clk);
      wr(`PCF_OFF_CTRL, 32'h0000_00fc);
      repeat (20) @(posedge clk);
      check(32'(skip_cnt > 5), 32'h0000_0001);
      skip_w = '0;
      $display("end of test: rate match");
      // manual byte ordering: ignored until triggered, then pad inserted
      {bo_pat, bo_pad} = {10'h155, 10'h0aa};
      wr(`PCF_OFF_BOCFG, 32'({bo_pad, bo_pat}));
      wr(`PCF_OFF_IMASK, 32'h0000_0080);
      wr(`PCF_OFF_CTRL, 32'h0000_03fc);
      wr(`PCF_OFF_ISTAT, 32'h0000_00ff);
      bo_on = 1'b1;
      rx_send({10'h155, 10'h003});
      rx_pcs_valid <= 1'b0;
      repeat (8) @(negedge clk);
      check(32'(irq), 32'h0000_0000);
      @(posedge clk);
      pulse_req <= 1'b1;
      @(posedge clk);
      pulse_req <= 1'b0;
      repeat (4) @(posedge clk);
      bo_arm = 1'b1;
      rx_send({10'h155, 10'h003});
      rx_send({10'h007, 10'h009});
      rx_pcs_valid <= 1'b0;
      repeat (10) @(negedge clk);
      check(32'(irq), 32'h0000_0001);
      @(posedge clk);
      wr(`PCF_OFF_ISTAT, 32'h0000_0080);
      @(negedge clk);
      check(32'(irq), 32'h0000_0000);
      $display("end of test: byte ordering");
      complete_run();
   end

   // hang guard, well past the few hundred cycles the tests take
   initial
   begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : test_pcf_phase_comp
